// >>> hw/sdlcrx_pkg.sv
/*
 * sdlcrx_pkg: constants shared by the serial receive and command port block.
 * Assumes a single channel instance; the channel select pin tells which one.
 */
package sdlcrx_pkg;
    // register pointer values
    localparam logic [2:0] PTR_CMD = 3'h0;
    localparam logic [2:0] PTR_INT_CTRL = 3'h1;
    localparam logic [2:0] PTR_VECTOR = 3'h2;
    localparam logic [2:0] PTR_RX_CTRL = 3'h3;
    localparam logic [2:0] PTR_MODE = 3'h4;
    localparam logic [2:0] PTR_TX_CTRL = 3'h5;
    localparam logic [2:0] PTR_SEC_ADDR = 3'h6;
    localparam logic [2:0] PTR_FLAG = 3'h7;
    // command byte fields
    localparam int CRC_HI = 7;
    localparam int CRC_LO = 6;
    localparam int CMD_HI = 5;
    localparam int CMD_LO = 3;
    localparam int PTR_HI = 2;
    // command codes
    localparam logic [2:0] CMD_NULL = 3'h0;
    localparam logic [2:0] CMD_ABORT = 3'h1;
    localparam logic [2:0] CMD_RST_EXT = 3'h2;
    localparam logic [2:0] CMD_CH_RST = 3'h3;
    localparam logic [2:0] CMD_EN_NEXT = 3'h4;
    localparam logic [2:0] CMD_RST_TXP = 3'h5;
    localparam logic [2:0] CMD_ERR_RST = 3'h6;
    localparam logic [2:0] CMD_RETI = 3'h7;
    // crc reset codes
    localparam logic [1:0] CRC_NULL = 2'h0;
    localparam logic [1:0] CRC_RST_RX = 2'h1;
    // interrupt control bits
    localparam int IC_EXT_EN = 0;
    localparam int IC_SAV = 2;
    localparam int IC_RXM0 = 3;
    localparam int IC_RXM1 = 4;
    localparam int IC_WR_EN = 7;
    // receive control bits
    localparam int RC_RX_EN = 0;
    localparam int RC_ADDR_SRCH = 2;
    localparam int RC_HUNT = 4;
    localparam int RC_AUTO_EN = 5;
    // status bit positions
    localparam int S0_RX_AVAIL = 0;
    localparam int S0_CD = 3;
    localparam int S0_ABORT = 7;
    localparam int S1_RES_LO = 1;
    localparam int S1_OVR = 5;
    localparam int S1_CRC_ERR = 6;
    localparam int S1_EOF = 7;
    // link constants
    localparam logic [7:0] FLAG_RESET = 8'h7E;
    localparam logic [7:0] GLOBAL_ADDR = 8'hFF;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [15:0] CRC_GOOD = 16'hF0B8;
    localparam logic [2:0] ABORT_ONES = 3'h7;
    // vector offsets, shifted into bits 3..1 when status affects vector
    localparam logic [2:0] VEC_EXT = 3'h1;
    localparam logic [2:0] VEC_RX = 3'h2;
    localparam logic [2:0] VEC_SPECIAL = 3'h3;
    localparam logic [2:0] CH_B_MSB = 3'h4;
endpackage : sdlcrx_pkg

// >>> hw/sdlcrx_port.sv
/*
 * sdlcrx_port: one channel's command/pointer port and bit-oriented receiver.
 * Assumes host strobes are synchronous to i_clk; the line arrives on its own
 * receive clock, and carrier detect is an asynchronous pin.
 */
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Functional notes
// - with receive interrupts on, closing flag raises special vector.
// - at frame end second status holds valid three-bit residue.
// - seven or more ones set abort status, external interrupt if enabled.
// - after ext reset during abort, end of ones raises another interrupt.
// - receive crc covers every character, no hold-back delay.
// - crc result complete when second crc character enters buffer.
// - programmed flag pattern delimits frames; host loads 0111 1110.
// - with auto enables, a frame is entered only if carrier detect is active at its opening flag.
// - address search accepts frame on secondary or global address.
// - first-character mode interrupts once on matched address.
// - carrier change and abort raise external; overrun raises special.
// - end-of-frame flag interrupts and drops wait/ready.
// - error reset command clears the special condition latches.
// - abort end clears abort status and raises interrupt.
// - status affects vector only effective in second channel.
// - data select 0 data, 1 command; channel 0 first, 1 second.
// - non-command registers written with pointer byte then data byte.
// - any reset points the pointer at the command register.
// - command byte: crc code 7..6, command 5..3, pointer 2..0.
// - command and crc bits decoded from every first byte.
// - after pointing, either read or write of selected register.
// - after any non-command access the pointer returns to zero.
// - global address is all ones.
// - command codes 0..7 as null, abort, ext, reset, next, txp, err, reti.
// - crc codes: null, reset rx checker, reset tx gen, reset eom latch.
module sdlcrx_port (
    input wire logic i_clk,         // system clock, 250 MHz
    input wire logic i_rst,         // async reset, active high
    input wire logic i_rx_clk,      // serial receive clock
    input wire logic i_rx_data,     // serial receive data
    input wire logic i_cd_n,        // carrier detect pin, active low
    input wire logic i_chan_b,      // channel select: 1 = second channel
    input wire logic i_ctl,         // 1 = command/status, 0 = data
    input wire logic i_wr,          // one-cycle write strobe
    input wire logic i_rd,          // one-cycle read strobe
    input wire logic [7:0] i_wdata, // write data
    output logic [7:0] o_rdata,     // read data, registered
    output logic o_int,             // interrupt request, high
    output logic [7:0] o_vector,    // vector presented
    output logic o_ready            // wait/ready, high = byte ready
);

    ////////////////////////////////////////////////////////////////////////
    // host side state
    logic [2:0] ptr, next_ptr;
    logic [7:0] int_ctrl, next_int_ctrl;
    logic [7:0] vec_base, next_vec_base;
    logic [7:0] rx_ctrl, next_rx_ctrl;
    logic [7:0] mode, next_mode;
    logic [7:0] tx_ctrl, next_tx_ctrl;
    logic [7:0] sec_addr, next_sec_addr;
    logic [7:0] flag_pat, next_flag_pat;
    logic [7:0] rx_buf, next_rx_buf;
    logic buf_full, next_buf_full;
    logic ovr, next_ovr;
    logic eof_st, next_eof_st;
    logic crc_err, next_crc_err;
    logic [2:0] residue, next_residue;
    logic ext_latched, next_ext_latched;
    logic ext_pend, next_ext_pend;
    logic [7:0] st0_lat, next_st0_lat;
    logic first_armed, next_first_armed;
    logic rx_pend, next_rx_pend;
    logic [7:0] rdata, next_rdata;
    logic [7:0] vector, next_vector;
    logic intr, next_intr;
    logic ready, next_ready;
    logic hunt_req, next_hunt_req;
    logic crc_req, next_crc_req;

    // carrier detect pin synchroniser
    logic cd_m, cd_s;
    // link/host crossings: toggles for events and host requests, abort as a level, word held stable
    logic [2:0] byte_t_s, eof_t_s;
    logic [1:0] ab_s;
    logic hunt_t_s0, hunt_t_s1, crc_t_s0, crc_t_s1;

    // link side state
    logic [7:0] sh, frame_byte, l_data;
    logic [2:0] bitcnt, ones, l_res;
    logic in_frame, addr_pend, frame_ok, l_abort, l_crc_err;
    logic [15:0] crc;
    logic byte_t, eof_t;
    logic hunt_seen, crc_seen;

    // shared crc step, used per bit on the link
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic b);
        crc_step = (c[0] ^ b) ? ((c >> 1) ^ sdlcrx_pkg::CRC_POLY)
                              : (c >> 1);
    endfunction : crc_step

    // the closing flag's first seven bits pass the checker before the flag
    // is recognised, so the good residue is carried through them as well
    function automatic logic [15:0] crc_flag(input logic [15:0] c,
                                             input logic [6:0] f);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 7; i++) r = crc_step(r, f[i]);
        crc_flag = r;
    endfunction : crc_flag

    ////////////////////////////////////////////////////////////////////////
    // synchronisers; first stage feeds only the second
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cd_m <= 1'b0;
            cd_s <= 1'b0;
            byte_t_s <= 3'h0;
            eof_t_s <= 3'h0;
            ab_s <= 2'h0;
        end else begin
            cd_m <= ~i_cd_n;
            cd_s <= cd_m;
            byte_t_s <= {byte_t_s[1:0], byte_t};
            eof_t_s <= {eof_t_s[1:0], eof_t};
            ab_s <= {ab_s[0], l_abort};
        end
    end

    // host-side derived events
    logic byte_ev, eof_ev, abort_s, cd_in;
    logic [7:0] st0_live, st1;
    logic wr_cmd, rd_cmd, ch_rst, sav_on;
    logic [2:0] cmd;
    assign byte_ev = byte_t_s[2] ^ byte_t_s[1];
    assign eof_ev = eof_t_s[2] ^ eof_t_s[1];
    assign abort_s = ab_s[1];
    assign cd_in = cd_s;
    // control select plus write gives command port access
    assign wr_cmd = i_wr & i_ctl;
    assign rd_cmd = i_rd & i_ctl;
    assign cmd = i_wdata[sdlcrx_pkg::CMD_HI:sdlcrx_pkg::CMD_LO];
    assign ch_rst = wr_cmd && (ptr == sdlcrx_pkg::PTR_CMD)
                    && (cmd == sdlcrx_pkg::CMD_CH_RST);
    // vector modified only in the second channel
    assign sav_on = int_ctrl[sdlcrx_pkg::IC_SAV] & i_chan_b;
    always_comb begin
        st0_live = 8'h00;
        st0_live[sdlcrx_pkg::S0_RX_AVAIL] = buf_full;
        st0_live[sdlcrx_pkg::S0_CD] = cd_in;
        st0_live[sdlcrx_pkg::S0_ABORT] = abort_s;
        st1 = 8'h00;
        st1[sdlcrx_pkg::S1_RES_LO +: 3] = residue;
        st1[sdlcrx_pkg::S1_OVR] = ovr;
        st1[sdlcrx_pkg::S1_CRC_ERR] = crc_err;
        st1[sdlcrx_pkg::S1_EOF] = eof_st;
    end

    ////////////////////////////////////////////////////////////////////////
    // command port, status latches and interrupt next-state
    always_comb begin
        logic rxm_on, special, ext_ev, st0_chg;
        logic [2:0] vcode;
        rxm_on = int_ctrl[sdlcrx_pkg::IC_RXM0] | int_ctrl[sdlcrx_pkg::IC_RXM1];
        special = 1'b0;
        ext_ev = 1'b0;
        st0_chg = 1'b0;
        vcode = sdlcrx_pkg::VEC_RX;
        next_ptr = ptr;
        next_int_ctrl = int_ctrl;
        next_vec_base = vec_base;
        next_rx_ctrl = rx_ctrl;
        next_mode = mode;
        next_tx_ctrl = tx_ctrl;
        next_sec_addr = sec_addr;
        next_flag_pat = flag_pat;
        next_rx_buf = rx_buf;
        next_buf_full = buf_full;
        next_ovr = ovr;
        next_eof_st = eof_st;
        next_crc_err = crc_err;
        next_residue = residue;
        next_ext_latched = ext_latched;
        next_ext_pend = ext_pend;
        next_st0_lat = st0_lat;
        next_first_armed = first_armed;
        next_rx_pend = rx_pend;
        next_rdata = rdata;
        next_hunt_req = hunt_req;
        next_crc_req = crc_req;
        next_ready = ready;
        // host data read drains the buffer
        if (i_rd && !i_ctl) begin
            next_rdata = rx_buf;
            next_buf_full = 1'b0;
            next_rx_pend = 1'b0;
        end
        if (rd_cmd) begin
            next_rdata = (ptr == sdlcrx_pkg::PTR_INT_CTRL) ? st1
                       : (ext_latched ? st0_lat : st0_live);
            next_ptr = sdlcrx_pkg::PTR_CMD;
        end
        // external/status: carrier or abort edge latches st0
        st0_chg = (cd_in != st0_lat[sdlcrx_pkg::S0_CD])
                  || (abort_s != st0_lat[sdlcrx_pkg::S0_ABORT]);
        ext_ev = !ext_latched && st0_chg;
        if (wr_cmd) begin
            if (ptr == sdlcrx_pkg::PTR_CMD) begin
                next_ptr = i_wdata[sdlcrx_pkg::PTR_HI:0];
            end else begin
                unique case (ptr)
                    sdlcrx_pkg::PTR_INT_CTRL: next_int_ctrl = i_wdata;
                    sdlcrx_pkg::PTR_VECTOR: next_vec_base = i_wdata;
                    sdlcrx_pkg::PTR_RX_CTRL: next_rx_ctrl = i_wdata;
                    sdlcrx_pkg::PTR_MODE: next_mode = i_wdata;
                    sdlcrx_pkg::PTR_TX_CTRL: next_tx_ctrl = i_wdata;
                    sdlcrx_pkg::PTR_SEC_ADDR: next_sec_addr = i_wdata;
                    sdlcrx_pkg::PTR_FLAG: next_flag_pat = i_wdata;
                    default: next_int_ctrl = int_ctrl;
                endcase
                next_ptr = sdlcrx_pkg::PTR_CMD;
                if (ptr == sdlcrx_pkg::PTR_RX_CTRL
                    && i_wdata[sdlcrx_pkg::RC_HUNT])
                    next_hunt_req = ~hunt_req;
            end
            // command/crc taken from the pointer byte
            if (ptr == sdlcrx_pkg::PTR_CMD) begin
                unique case (cmd)
                    sdlcrx_pkg::CMD_RST_EXT: begin
                        next_ext_latched = 1'b0;
                        next_ext_pend = 1'b0;
                        next_st0_lat = st0_live;
                    end
                    sdlcrx_pkg::CMD_EN_NEXT: next_first_armed = 1'b1;
                    sdlcrx_pkg::CMD_ERR_RST: begin
                        next_ovr = 1'b0;
                        next_eof_st = 1'b0;
                        next_crc_err = 1'b0;
                    end
                    default: next_ptr = next_ptr; // channel reset acts through ch_rst; the rest have no receive-side effect
                endcase
                // only the receive checker reset lives here
                if (i_wdata[sdlcrx_pkg::CRC_HI:sdlcrx_pkg::CRC_LO]
                    == sdlcrx_pkg::CRC_RST_RX)
                    next_crc_req = ~crc_req;
            end
        end
        // after the commands, so an event beside an unlatch still latches unless st0 was already latched
        if (ext_ev) begin
            next_st0_lat = st0_live;
            next_ext_latched = 1'b1;
            next_ext_pend = int_ctrl[sdlcrx_pkg::IC_EXT_EN];
        end
        // byte arrival; set beats a same-cycle read (written last)
        if (byte_ev) begin
            if (buf_full && !(i_rd && !i_ctl))
                next_ovr = 1'b1;
            next_rx_buf = l_data;
            next_buf_full = 1'b1;
            if (first_armed && int_ctrl[sdlcrx_pkg::IC_RXM0]
                && !int_ctrl[sdlcrx_pkg::IC_RXM1]) begin
                next_rx_pend = 1'b1;
                next_first_armed = 1'b0;
            end else if (int_ctrl[sdlcrx_pkg::IC_RXM1])
                next_rx_pend = 1'b1;
        end
        if (eof_ev) begin
            next_eof_st = 1'b1;
            next_crc_err = l_crc_err;
            next_residue = l_res;
        end
        // frame end drops wait/ready
        next_ready = int_ctrl[sdlcrx_pkg::IC_WR_EN] && next_buf_full
                     && !next_eof_st;
        special = rxm_on && (next_eof_st || next_ovr);
        next_intr = special || next_ext_pend || next_rx_pend;
        vcode = special ? sdlcrx_pkg::VEC_SPECIAL
              : next_ext_pend ? sdlcrx_pkg::VEC_EXT : sdlcrx_pkg::VEC_RX;
        next_vector = vec_base;
        if (sav_on)
            next_vector[3:1] = vcode | (i_chan_b ? 3'h0 : sdlcrx_pkg::CH_B_MSB);
        if (ch_rst) begin
            next_ptr = sdlcrx_pkg::PTR_CMD;
            next_int_ctrl = 8'h00;
            next_rx_ctrl = 8'h00;
            next_ext_pend = 1'b0;
            next_rx_pend = 1'b0;
            next_intr = 1'b0;
            next_ready = 1'b0;
        end
    end

    // host registers
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ptr <= sdlcrx_pkg::PTR_CMD;
            int_ctrl <= 8'h00;
            vec_base <= 8'h00;
            rx_ctrl <= 8'h00;
            mode <= 8'h00;
            tx_ctrl <= 8'h00;
            sec_addr <= 8'h00;
            flag_pat <= sdlcrx_pkg::FLAG_RESET;
            rx_buf <= 8'h00;
            buf_full <= 1'b0;
            ovr <= 1'b0;
            eof_st <= 1'b0;
            crc_err <= 1'b0;
            residue <= 3'h0;
            ext_latched <= 1'b0;
            ext_pend <= 1'b0;
            st0_lat <= 8'h00;
            first_armed <= 1'b0;
            rx_pend <= 1'b0;
            rdata <= 8'h00;
            vector <= 8'h00;
            intr <= 1'b0;
            ready <= 1'b0;
            hunt_req <= 1'b0;
            crc_req <= 1'b0;
        end else begin
            ptr <= next_ptr;
            int_ctrl <= next_int_ctrl;
            vec_base <= next_vec_base;
            rx_ctrl <= next_rx_ctrl;
            mode <= next_mode;
            tx_ctrl <= next_tx_ctrl;
            sec_addr <= next_sec_addr;
            flag_pat <= next_flag_pat;
            rx_buf <= next_rx_buf;
            buf_full <= next_buf_full;
            ovr <= next_ovr;
            eof_st <= next_eof_st;
            crc_err <= next_crc_err;
            residue <= next_residue;
            ext_latched <= next_ext_latched;
            ext_pend <= next_ext_pend;
            st0_lat <= next_st0_lat;
            first_armed <= next_first_armed;
            rx_pend <= next_rx_pend;
            rdata <= next_rdata;
            vector <= next_vector;
            intr <= next_intr;
            ready <= next_ready;
            hunt_req <= next_hunt_req;
            crc_req <= next_crc_req;
        end
    end

    assign o_rdata = rdata;
    assign o_int = intr;
    assign o_vector = vector;
    assign o_ready = ready;

    ////////////////////////////////////////////////////////////////////////
    // link side; config words are quasi-static, written before enabling
    logic [7:0] sh_n;
    logic l_cd_m, l_cd;
    assign sh_n = {i_rx_data, sh[7:1]};
    always_ff @(posedge i_rx_clk or posedge i_rst) begin
        if (i_rst) begin
            l_cd_m <= 1'b0;
            l_cd <= 1'b0;
            hunt_t_s0 <= 1'b0;
            hunt_t_s1 <= 1'b0;
            crc_t_s0 <= 1'b0;
            crc_t_s1 <= 1'b0;
        end else begin
            l_cd_m <= cd_s; // re-synchronised into the link clock
            l_cd <= l_cd_m;
            hunt_t_s0 <= hunt_req;
            hunt_t_s1 <= hunt_t_s0;
            crc_t_s0 <= crc_req;
            crc_t_s1 <= crc_t_s0;
        end
    end

    // bit engine: flag, abort, zero deletion, address filter, crc
    always_ff @(posedge i_rx_clk or posedge i_rst) begin
        if (i_rst) begin
            sh <= 8'h00;
            frame_byte <= 8'h00;
            l_data <= 8'h00;
            bitcnt <= 3'h0;
            ones <= 3'h0;
            l_res <= 3'h0;
            in_frame <= 1'b0;
            addr_pend <= 1'b0;
            frame_ok <= 1'b0;
            l_abort <= 1'b0;
            l_crc_err <= 1'b0;
            crc <= sdlcrx_pkg::CRC_INIT;
            byte_t <= 1'b0;
            eof_t <= 1'b0;
            hunt_seen <= 1'b0;
            crc_seen <= 1'b0;
        end else begin
            sh <= sh_n;
            hunt_seen <= hunt_t_s1;
            crc_seen <= crc_t_s1;
            ones <= i_rx_data ? ((ones == sdlcrx_pkg::ABORT_ONES) ? ones
                                 : ones + 3'h1) : 3'h0;
            if (i_rx_data && ones == 3'h6) begin
                l_abort <= 1'b1;
                in_frame <= 1'b0;
            end else if (!i_rx_data)
                l_abort <= 1'b0;
            if (hunt_seen != hunt_t_s1)
                in_frame <= 1'b0;
            if (crc_seen != crc_t_s1)
                crc <= sdlcrx_pkg::CRC_INIT;
            if (sh_n == flag_pat) begin
                if (in_frame && frame_ok) begin
                    eof_t <= ~eof_t;
                    l_crc_err <= (crc != crc_flag(sdlcrx_pkg::CRC_GOOD,
                                                  flag_pat[6:0]));
                    // seven flag bits were counted too
                    l_res <= bitcnt + 3'h1;
                end
                // receiver gated by carrier under auto enables
                in_frame <= rx_ctrl[sdlcrx_pkg::RC_RX_EN]
                            && (l_cd || !rx_ctrl[sdlcrx_pkg::RC_AUTO_EN]);
                addr_pend <= 1'b1;
                frame_ok <= 1'b0;
                bitcnt <= 3'h0;
                crc <= sdlcrx_pkg::CRC_INIT;
            end else if (in_frame && !(ones == 3'h5 && !i_rx_data)) begin
                // zero after five ones is stuffing and is dropped
                crc <= crc_step(crc, i_rx_data);
                frame_byte <= {i_rx_data, frame_byte[7:1]};
                bitcnt <= bitcnt + 3'h1;
                if (bitcnt == 3'h7) begin
                    addr_pend <= 1'b0;
                    if (addr_pend && rx_ctrl[sdlcrx_pkg::RC_ADDR_SRCH]
                        && {i_rx_data, frame_byte[7:1]} != sec_addr
                        && {i_rx_data, frame_byte[7:1]}
                           != sdlcrx_pkg::GLOBAL_ADDR)
                        in_frame <= 1'b0;
                    else begin
                        frame_ok <= 1'b1;
                        l_data <= {i_rx_data, frame_byte[7:1]};
                        byte_t <= ~byte_t;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_ptr_return;
        @(posedge i_clk) disable iff (i_rst)
        (wr_cmd && ptr != sdlcrx_pkg::PTR_CMD && !ch_rst)
            |=> ptr == sdlcrx_pkg::PTR_CMD;
    endproperty
    a_ptr_return: assert property (p_ptr_return)
        else $error("pointer did not return to command register");

    property p_eof_ready;
        @(posedge i_clk) disable iff (i_rst)
        eof_ev |=> !o_ready && eof_st;
    endproperty
    a_eof_ready: assert property (p_eof_ready)
        else $error("frame end left wait/ready active");

    property p_err_reset;
        @(posedge i_clk) disable iff (i_rst)
        (wr_cmd && ptr == sdlcrx_pkg::PTR_CMD
         && cmd == sdlcrx_pkg::CMD_ERR_RST && !byte_ev && !eof_ev)
            |=> !ovr && !eof_st;
    endproperty
    a_err_reset: assert property (p_err_reset)
        else $error("error reset left latches set");

    property p_sav_a;
        @(posedge i_clk) disable iff (i_rst)
        !i_chan_b ##1 !i_chan_b |-> o_vector == $past(vec_base);
    endproperty
    a_sav_a: assert property (p_sav_a)
        else $error("first channel modified vector");

    property p_rd_ptr;
        @(posedge i_clk) disable iff (i_rst)
        rd_cmd && !i_wr |=> ptr == sdlcrx_pkg::PTR_CMD;
    endproperty
    a_rd_ptr: assert property (p_rd_ptr)
        else $error("status read left the pointer set");

    property p_abort_int;
        @(posedge i_clk) disable iff (i_rst)
        ($rose(abort_s) && !ext_latched && !i_wr
         && int_ctrl[sdlcrx_pkg::IC_EXT_EN])
            |=> o_int && st0_lat[sdlcrx_pkg::S0_ABORT];
    endproperty
    a_abort_int: assert property (p_abort_int)
        else $error("abort did not raise external interrupt");

endmodule : sdlcrx_port

`default_nettype wire

// >>> verif/sdlcrx_port_tb.sv
/*
 * sdlcrx_port_tb: self-checking bench for the receive and command port.
 * Assumes the station model drives the link; carrier held active.
 */
`timescale 1ns/1ps
`default_nettype none
module sdlcrx_port_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ctl = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic chb = 1'b0;
    logic [7:0] wd = 8'h00;
    logic [7:0] rdat, sec, got, vec;
    logic irq, rdy, rxc, rxd, busy;
    logic [7:0] rxq[$];
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    always #2 clk = ~clk;
    sdlcrx_port u_sdlcrx_port (.i_clk(clk), .i_rst(rst), .i_rx_clk(rxc),
        .i_rx_data(rxd), .i_cd_n(1'b0), .i_chan_b(chb), .i_ctl(ctl),
        .i_wr(wr), .i_rd(rd), .i_wdata(wd), .o_rdata(rdat), .o_int(irq),
        .o_vector(vec), .o_ready(rdy));
    sdlcrx_station u_sdlcrx_station (.o_clk(rxc), .o_data(rxd));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        comparisons++;
        if (seen !== want) begin
            errors++;
            $display("ERROR %0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic stop_test();
        if (errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test
    // a hung link or handshake ends the run as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            stop_test();
        end
    end
    task automatic wr_b(input logic c, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        ctl <= c;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_b
    task automatic rd_b(input logic c, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        ctl <= c;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdat;
    endtask : rd_b
    task automatic chk_reg(logic [2:0] p, logic [7:0] m, logic [7:0] w);
        wr_b(1'b1, {5'h00, p});
        rd_b(1'b1, got);
        check(got & m, w);
    endtask : chk_reg
    // frame with reflected check word; dma-like loop drains on ready
    task automatic run(input logic [7:0] a, input logic bad);
        logic [7:0] q[$];
        logic [15:0] c;
        logic [7:0] b;
        q = '{a, 8'($urandom)};
        c = sdlcrx_pkg::CRC_INIT;
        foreach (q[i]) for (int k = 0; k < 8; k++)
            c = (c >> 1) ^ ((c[0] ^ q[i][k]) ? sdlcrx_pkg::CRC_POLY : 16'h0);
        c = ~c ^ {15'h0, bad};
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        rxq.delete();
        busy = 1'b1;
        fork
            begin
                u_sdlcrx_station.frame(q);
                busy = 1'b0;
            end
            while (busy) begin
                @(negedge clk);
                if (rdy === 1'b1) begin
                    rd_b(1'b0, b);
                    rxq.push_back(b);
                end
            end
        join
        repeat (20) @(posedge clk);
        if (a == sec || a == 8'hFF) begin
            check(8'(rxq.size()), 8'h04);
            check(rxq[1], q[1]);
        end
    endtask : run
    initial begin
        void'($urandom(32'h0a5aa281));
        sec = {1'b0, 7'($urandom)};
        fork
            u_sdlcrx_station.raw(8'hFF, 1);
        join_none
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        check({7'h0, irq}, 8'h00);
        wr_b(1'b1, 8'h04);
        wr_b(1'b1, 8'h20);
        wr_b(1'b1, 8'h02);
        wr_b(1'b1, 8'hA0);
        wr_b(1'b1, 8'h07);
        wr_b(1'b1, 8'h7E);
        wr_b(1'b1, 8'h06);
        wr_b(1'b1, sec);
        wr_b(1'b1, 8'h01);
        wr_b(1'b1, 8'h8D);
        wr_b(1'b1, 8'h53);
        wr_b(1'b1, 8'h15);
        wr_b(1'b1, 8'h20);
        run(sec, 1'b0);
        check(rxq[0], sec);
        check({7'h0, irq}, 8'h01);
        check({7'h0, rdy}, 8'h00);
        chk_reg(3'h1, 8'hFF, 8'h80);
        wr_b(1'b1, 8'h30);
        chk_reg(3'h1, 8'hFF, 8'h00);
        run(8'hFF, 1'b1);
        check(rxq[0], 8'hFF);
        chk_reg(3'h1, 8'hFF, 8'hC0);
        wr_b(1'b1, 8'h30);
        run(sec ^ 8'h01, 1'b0);
        check(8'(rxq.size()), 8'h00);
        check({7'h0, irq}, 8'h00);
        u_sdlcrx_station.raw(8'hFF, 8);
        repeat (20) @(posedge clk);
        check({7'h0, irq}, 8'h01);
        chk_reg(3'h0, 8'h80, 8'h80);
        check(vec, 8'hA0);
        chb <= 1'b1;
        repeat (2) @(posedge clk);
        check(vec, 8'hA2);
        wr_b(1'b1, 8'h10);
        u_sdlcrx_station.raw(8'h7E, 8);
        repeat (20) @(posedge clk);
        check({7'h0, irq}, 8'h01);
        chk_reg(3'h0, 8'h80, 8'h00);
        stop_test();
    end
endmodule : sdlcrx_port_tb
`default_nettype wire

// >>> verif/sdlcrx_station.sv
/*
 * sdlcrx_station: remote bit-oriented sender for the receive port.
 * Assumes the receiver samples on the rising edge; clock idles low.
 */
`timescale 1ns/1ps
`default_nettype none
module sdlcrx_station (
    output logic o_clk, // link clock, still between frames
    output logic o_data // serial data, lsb first
);
    int ones = 0;
    initial begin
        o_clk = 1'b0;
        o_data = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    // one bit per 32 ns, data set up a half period before the rise
    task automatic bit_out(input logic b);
        o_data = b;
        #16 o_clk = 1'b1;
        #16 o_clk = 1'b0;
    endtask : bit_out
    // raw bits without zero insertion, for flags and aborts
    task automatic raw(input logic [7:0] v, input int n);
        for (int i = 0; i < n; i++) bit_out(v[i % 8]);
        ones = 0;
    endtask : raw
    // a zero after five ones keeps data from looking like a flag
    task automatic put_byte(input logic [7:0] v);
        for (int i = 0; i < 8; i++) begin
            bit_out(v[i]);
            ones = v[i] ? ones + 1 : 0;
            if (ones == 5) begin
                bit_out(1'b0);
                ones = 0;
            end
        end
    endtask : put_byte
    task automatic frame(input logic [7:0] q[$]);
        raw(8'h7E, 8);
        foreach (q[i]) put_byte(q[i]);
        raw(8'h7E, 8);
        o_data = ~o_data; // released line must not hold the last bit
    endtask : frame
endmodule : sdlcrx_station
`default_nettype wire
